// file: design/ifd_defines.vh
// constants for the instruction format decoder
//
// Overview of operation
// - destination bit 0 sends result to accumulator, 1 back to file register
// - bank access bit 0 forces access bank, 1 uses bank selector
// - byte and bit formats carry an 8-bit file address in bits 7..0
// - file-to-file move: 12-bit source, then 1111 word with 12-bit destination
// - bit formats select the bit with bits 11..9
// - literal formats take an 8-bit immediate from the low byte
// - call and goto build a 20-bit target from two words
// - fast bit 1 saves or restores shadow registers, 0 leaves them
// - branch offsets are two's complement, 11 bits or 8 bits
// - table ops support none, post-increment, post-decrement, pre-increment
// - table pointer is 21 bits, one byte moves through the table latch
// - pointer load: first word selects pointer, second word 1111 0000 plus low byte
// - multiply product goes to high byte 0xFF4 and low byte 0xFF3
// - five arithmetic flags: carry, digit carry, zero, overflow, negative
// - a standalone word with top nibble 1111 is a no-operation
// - an instruction cycle is four clocks; one or two cycles per instruction
`ifndef IFD_DEFINES_VH
`define IFD_DEFINES_VH
`define IFD_ADDR_ACC    12'hFE8
`define IFD_ADDR_PROD_LO 12'hFF3
`define IFD_ADDR_PROD_HI 12'hFF4
`define IFD_ADDR_TLATCH 12'hFF5
`define IFD_ADDR_TPL    12'hFF6
`define IFD_ADDR_TPH    12'hFF7
`define IFD_ADDR_TPU    12'hFF8
`define IFD_ADDR_PC_LO  12'hFF9
`define IFD_ADDR_PCLH   12'hFFA
`define IFD_ADDR_PCLU   12'hFFB
`define IFD_ADDR_BANK   12'hFE0
`define IFD_ADDR_FLAGS  12'hFE1
`define IFD_D_BIT       9
`define IFD_A_BIT       8
`define IFD_EXT_NIB     4'hF
`define IFD_MOVE_NIB    4'hC
`define IFD_PTR2_HI     4'h0
`define IFD_ACCESS_SPLIT 8'h80
`define IFD_ACCESS_HI   4'hF
`define IFD_ACCESS_LO   4'h0
`define IFD_LAST_PHASE  2'h3
`define IFD_FMT_NONE    4'h0
`define IFD_FMT_BYTE    4'h1
`define IFD_FMT_BIT     4'h2
`define IFD_FMT_LIT     4'h3
`define IFD_FMT_MOVE    4'h4
`define IFD_FMT_CALL    4'h5
`define IFD_FMT_GOTO    4'h6
`define IFD_FMT_BRANCH  4'h7
`define IFD_FMT_BCOND   4'h8
`define IFD_FMT_PTR_LOAD 4'h9
`define IFD_FMT_TBL     4'hA
`define IFD_FMT_RET     4'hB
`define IFD_FMT_NOP     4'hC
`define IFD_FMT_MISC    4'hD
`define IFD_TM_NONE     2'h0
`define IFD_TM_POSTINC  2'h1
`define IFD_TM_POSTDEC  2'h2
`define IFD_TM_PREINC   2'h3
`endif

// file: design/ifd_decoder.v
// instruction format decoder with its special-function registers
//
// Local design decision: strobed register access.
`include "ifd_defines.vh"
module ifd_decoder (
  input  wire        CLK_SYS,
  input  wire        RST_B,
  input  wire [15:0] INSTR_WORD,
  input  wire        INSTR_VALID,
  input  wire [7:0]  OPERAND_DATA,
  input  wire        ALU_FLAGS_WE,
  input  wire [4:0]  ALU_FLAGS,
  input  wire [7:0]  TBL_RDATA,
  input  wire        TBL_RVALID,
  input  wire [11:0] ADDR,
  input  wire [7:0]  WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [7:0]  RDATA,
  output reg         FETCH,
  output reg         DEC_VALID,
  output reg  [3:0]  FORMAT,
  output reg         IS_NOP,
  output reg         DEST_ACC,
  output reg  [11:0] FILE_ADDR,
  output reg  [2:0]  BIT_SEL,
  output reg  [7:0]  LITERAL,
  output reg  [11:0] SRC_ADDR,
  output reg  [11:0] DST_ADDR,
  output reg  [19:0] TARGET,
  output reg         FAST_SHADOW,
  output reg  [10:0] BR_OFFSET,
  output reg  [1:0]  PTR_SEL,
  output reg  [11:0] PTR_VALUE,
  output reg  [1:0]  EXEC_CYCLES,
  output reg         COND_EXTEND,
  output reg         TBL_REQ,
  output reg         TBL_WRITE,
  output reg  [20:0] TBL_ADDR,
  output reg  [7:0]  TBL_WDATA,
  output reg  [4:0]  FLAGS
);

  reg  [1:0]  phase;
  reg         pend;
  reg  [15:0] first;
  reg  [3:0]  pend_fmt;
  reg  [7:0]  working_accumulator;
  reg  [7:0]  product_low_byte;
  reg  [7:0]  product_high_byte;
  reg  [7:0]  table_byte_latch;
  reg  [20:0] program_table_pointer;
  reg  [7:0]  program_counter_low;
  reg  [7:0]  program_counter_high_latch;
  reg  [7:0]  program_counter_upper_latch;
  reg  [7:0]  bank_selector;

  reg  [3:0]  next_fmt;
  reg         next_two;
  reg  [1:0]  next_cycles;
  reg         next_cond;
  reg         next_fast;
  reg  [11:0] next_file;
  reg  [10:0] next_off;
  reg  [20:0] next_ptr;
  reg  [20:0] tbl_use;

  wire        take;
  wire [15:0] w;
  wire [7:0]  f;
  wire        is_mul;
  wire [15:0] product;

  assign w = INSTR_WORD;
  assign f = w[7:0];
  assign take = INSTR_VALID && (phase == `IFD_LAST_PHASE);
  assign is_mul = (w[15:9] == 7'h01);
  // both operands widened so the full 16-bit product is kept
  assign product = {8'h00, working_accumulator} * {8'h00, OPERAND_DATA};

  // classify the first word; only bits belonging to a field or an opcode
  // are looked at, so don't-care positions cannot steer the result
  always @* begin
    next_fmt = `IFD_FMT_MISC;
    next_two = 1'b0;
    next_cycles = 2'h1;
    next_cond = 1'b0;
    next_fast = 1'b0;
    if (w[15:12] == `IFD_EXT_NIB) begin
      next_fmt = `IFD_FMT_NOP;
    end else if (w[15:12] == `IFD_MOVE_NIB) begin
      next_fmt = `IFD_FMT_MOVE;
      next_two = 1'b1;
    end else if (w[15:8] == 8'hEF) begin
      next_fmt = `IFD_FMT_GOTO;
      next_two = 1'b1;
    end else if (w[15:9] == 7'h76) begin
      next_fmt = `IFD_FMT_CALL;
      next_two = 1'b1;
      next_fast = w[8];
    end else if (w[15:8] == 8'hEE && w[7:6] == 2'h0) begin
      next_fmt = `IFD_FMT_PTR_LOAD;
      next_two = 1'b1;
    end else if (w[15:11] == 5'h1A) begin
      next_fmt = `IFD_FMT_BRANCH;
      next_cycles = 2'h2;
    end else if (w[15:11] == 5'h1C) begin
      next_fmt = `IFD_FMT_BCOND;
      next_cond = 1'b1;
    end else if (w[15:12] >= 4'h7 && w[15:12] <= 4'hB) begin
      next_fmt = `IFD_FMT_BIT;
      next_cond = w[13];
    end else if (w[15:11] == 5'h01) begin
      next_fmt = `IFD_FMT_LIT;
    end else if (w[15:4] == 12'h000 && w[3]) begin
      next_fmt = `IFD_FMT_TBL;
      next_cycles = 2'h2;
    end else if (w[15:2] == 14'h0004) begin
      next_fmt = `IFD_FMT_RET;
      next_cycles = 2'h2;
      next_fast = w[0];
    end else if (w[15:12] <= 4'h6 && w[15:8] != 8'h00) begin
      next_fmt = `IFD_FMT_BYTE;
      next_cond = (w[15:12] == 4'h6) && (w[11:9] <= 3'h3);
    end
    if (next_two) begin
      next_cycles = 2'h2;
    end
    // a byte op writing the program counter low byte changes the flow,
    // so it costs the extra cycle like any taken branch
    if (next_fmt == `IFD_FMT_BYTE && w[`IFD_D_BIT] && next_file == `IFD_ADDR_PC_LO) begin
      next_cycles = 2'h2;
    end
  end

  // access bank splits into low RAM and the special-function area
  always @* begin
    if (!w[`IFD_A_BIT]) begin
      if (f < `IFD_ACCESS_SPLIT) begin
        next_file = {`IFD_ACCESS_LO, f};
      end else begin
        next_file = {`IFD_ACCESS_HI, f};
      end
    end else begin
      next_file = {bank_selector[3:0], f};
    end
  end

  always @* begin
    if (next_fmt == `IFD_FMT_BRANCH) begin
      next_off = w[10:0];
    end else begin
      next_off = {{3{w[7]}}, w[7:0]};
    end
  end

  always @* begin
    tbl_use = program_table_pointer;
    next_ptr = program_table_pointer;
    case (w[1:0])
      `IFD_TM_NONE: begin
        next_ptr = program_table_pointer;
      end
      `IFD_TM_POSTINC: begin
        next_ptr = program_table_pointer + 21'h000001;
      end
      `IFD_TM_POSTDEC: begin
        next_ptr = program_table_pointer - 21'h000001;
      end
      `IFD_TM_PREINC: begin
        next_ptr = program_table_pointer + 21'h000001;
        tbl_use = next_ptr;
      end
      default: begin
        next_ptr = program_table_pointer;
      end
    endcase
  end

  always @(posedge CLK_SYS) begin
    if (!RST_B) begin
      phase <= 2'h0;
      FETCH <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      FETCH <= (phase == 2'h2);
    end
  end

  // decode path; a pending first word makes the next word its extension
  always @(posedge CLK_SYS) begin
    if (!RST_B) begin
      pend <= 1'b0;
      first <= 16'h0000;
      pend_fmt <= `IFD_FMT_NONE;
      DEC_VALID <= 1'b0;
      FORMAT <= `IFD_FMT_NONE;
      IS_NOP <= 1'b0;
      DEST_ACC <= 1'b0;
      FILE_ADDR <= 12'h000;
      BIT_SEL <= 3'h0;
      LITERAL <= 8'h00;
      SRC_ADDR <= 12'h000;
      DST_ADDR <= 12'h000;
      TARGET <= 20'h00000;
      FAST_SHADOW <= 1'b0;
      BR_OFFSET <= 11'h000;
      PTR_SEL <= 2'h0;
      PTR_VALUE <= 12'h000;
      EXEC_CYCLES <= 2'h0;
      COND_EXTEND <= 1'b0;
    end else begin
      DEC_VALID <= 1'b0;
      if (take && pend) begin
        // second word: top nibble is not checked, it is operand only
        pend <= 1'b0;
        DEC_VALID <= 1'b1;
        FORMAT <= pend_fmt;
        IS_NOP <= 1'b0;
        EXEC_CYCLES <= 2'h2;
        COND_EXTEND <= 1'b0;
        case (pend_fmt)
          `IFD_FMT_MOVE: begin
            SRC_ADDR <= first[11:0];
            DST_ADDR <= w[11:0];
          end
          `IFD_FMT_CALL, `IFD_FMT_GOTO: begin
            TARGET <= {w[11:0], first[7:0]};
            FAST_SHADOW <= (pend_fmt == `IFD_FMT_CALL) && first[8];
          end
          `IFD_FMT_PTR_LOAD: begin
            PTR_SEL <= first[5:4];
            PTR_VALUE <= {first[3:0], w[7:0]};
          end
          default: begin
            IS_NOP <= 1'b1;
          end
        endcase
      end else if (take) begin
        DEC_VALID <= !next_two;
        if (next_two) begin
          pend <= 1'b1;
          first <= w;
          pend_fmt <= next_fmt;
        end else begin
          FORMAT <= next_fmt;
          IS_NOP <= (next_fmt == `IFD_FMT_NOP);
          EXEC_CYCLES <= next_cycles;
          COND_EXTEND <= next_cond;
          DEST_ACC <= !w[`IFD_D_BIT];
          FILE_ADDR <= next_file;
          BIT_SEL <= w[11:9];
          LITERAL <= w[7:0];
          BR_OFFSET <= next_off;
          FAST_SHADOW <= next_fast;
        end
      end
    end
  end

  // special registers; hardware updates win over a software write in the
  // same cycle so that no decoded effect is lost
  always @(posedge CLK_SYS) begin
    if (!RST_B) begin
      working_accumulator <= 8'h00;
      product_low_byte <= 8'h00;
      product_high_byte <= 8'h00;
      table_byte_latch <= 8'h00;
      program_table_pointer <= 21'h000000;
      program_counter_low <= 8'h00;
      program_counter_high_latch <= 8'h00;
      program_counter_upper_latch <= 8'h00;
      bank_selector <= 8'h00;
      FLAGS <= 5'h00;
      TBL_REQ <= 1'b0;
      TBL_WRITE <= 1'b0;
      TBL_ADDR <= 21'h000000;
      TBL_WDATA <= 8'h00;
    end else begin
      TBL_REQ <= 1'b0;
      if (WR) begin
        case (ADDR)
          `IFD_ADDR_ACC: working_accumulator <= WDATA;
          `IFD_ADDR_PROD_LO: product_low_byte <= WDATA;
          `IFD_ADDR_PROD_HI: product_high_byte <= WDATA;
          `IFD_ADDR_TLATCH: table_byte_latch <= WDATA;
          `IFD_ADDR_TPL: program_table_pointer[7:0] <= WDATA;
          `IFD_ADDR_TPH: program_table_pointer[15:8] <= WDATA;
          `IFD_ADDR_TPU: program_table_pointer[20:16] <= WDATA[4:0];
          `IFD_ADDR_PC_LO: program_counter_low <= WDATA;
          `IFD_ADDR_PCLH: program_counter_high_latch <= WDATA;
          `IFD_ADDR_PCLU: program_counter_upper_latch <= WDATA;
          `IFD_ADDR_BANK: bank_selector <= {4'h0, WDATA[3:0]};
          `IFD_ADDR_FLAGS: FLAGS <= WDATA[4:0];
          default: begin
          end
        endcase
      end
      if (ALU_FLAGS_WE) begin
        FLAGS <= ALU_FLAGS;
      end
      if (take && !pend && is_mul) begin
        product_high_byte <= product[15:8];
        product_low_byte <= product[7:0];
      end
      if (take && !pend && next_fmt == `IFD_FMT_TBL) begin
        program_table_pointer <= next_ptr;
        TBL_ADDR <= tbl_use;
        TBL_REQ <= 1'b1;
        TBL_WRITE <= w[2];
        TBL_WDATA <= table_byte_latch;
      end
      if (TBL_RVALID) begin
        table_byte_latch <= TBL_RDATA;
      end
    end
  end

  // read data one cycle after the strobe; unmapped reads give zero
  always @(posedge CLK_SYS) begin
    if (!RST_B) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        `IFD_ADDR_ACC: RDATA <= working_accumulator;
        `IFD_ADDR_PROD_LO: RDATA <= product_low_byte;
        `IFD_ADDR_PROD_HI: RDATA <= product_high_byte;
        `IFD_ADDR_TLATCH: RDATA <= table_byte_latch;
        `IFD_ADDR_TPL: RDATA <= program_table_pointer[7:0];
        `IFD_ADDR_TPH: RDATA <= program_table_pointer[15:8];
        `IFD_ADDR_TPU: RDATA <= {3'h0, program_table_pointer[20:16]};
        `IFD_ADDR_PC_LO: RDATA <= program_counter_low;
        `IFD_ADDR_PCLH: RDATA <= program_counter_high_latch;
        `IFD_ADDR_PCLU: RDATA <= program_counter_upper_latch;
        `IFD_ADDR_BANK: RDATA <= bank_selector;
        `IFD_ADDR_FLAGS: RDATA <= {3'h0, FLAGS};
        default: RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

endmodule // ifd_decoder

// file: tb/ifd_prog_mem.sv
// program memory model feeding instruction words and table bytes
module ifd_prog_mem (
  input  wire logic        CLK_SYS,
  input  wire logic        FETCH,
  input  wire logic        TBL_REQ,
  input  wire logic        TBL_WRITE,
  input  wire logic [20:0] TBL_ADDR,
  output logic      [15:0] INSTR_WORD,
  output logic             INSTR_VALID,
  output logic      [7:0]  TBL_RDATA,
  output logic             TBL_RVALID
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rom [128];
  int          fill = 0;
  int          pc = 0;
  int          cnt = 0;
  logic        slow = 1'b0;
  logic [15:0] cyc = 16'h0000;
  logic [7:0]  pend = 8'h00;
  // no word queued: lines wander so a stale word is never mistaken for a fresh one
  assign INSTR_VALID = pc < fill;
  assign INSTR_WORD  = INSTR_VALID ? rom[pc] : cyc ^ 16'hA5A5;
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 16'h0001;
    if (FETCH && INSTR_VALID) pc <= pc + 1;
    TBL_RVALID <= cnt == 1;
    TBL_RDATA <= cnt == 1 ? pend : ~pend;
    if (TBL_REQ && !TBL_WRITE) begin
      cnt <= slow ? 3 : 1;
      pend <= TBL_ADDR[7:0] ^ 8'h3C;
    end else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule // ifd_prog_mem

// file: tb/ifd_decoder_assertions.sv
// concurrent checks on the decoder ports
`include "ifd_defines.vh"
module ifd_decoder_chk (
  input wire        CLK_SYS,
  input wire        RST_B,
  input wire [15:0] INSTR_WORD,
  input wire        INSTR_VALID,
  input wire        ALU_FLAGS_WE,
  input wire [4:0]  ALU_FLAGS,
  input wire        FETCH,
  input wire        DEC_VALID,
  input wire [3:0]  FORMAT,
  input wire        DEST_ACC,
  input wire [11:0] FILE_ADDR,
  input wire [2:0]  BIT_SEL,
  input wire [7:0]  LITERAL,
  input wire [11:0] SRC_ADDR,
  input wire [11:0] DST_ADDR,
  input wire        TBL_REQ,
  input wire        TBL_WRITE,
  input wire [4:0]  FLAGS
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  wire take = FETCH && INSTR_VALID;
  sequence mv_word;
    take && INSTR_WORD[15:12] == `IFD_MOVE_NIB;
  endsequence
  sequence tbl_word;
    take && INSTR_WORD[15:4] == 12'h000 && INSTR_WORD[3];
  endsequence
  fetch_slot_a: assert property (FETCH |=> !FETCH [*3] ##1 FETCH)
    else $error("fetch slot not every fourth cycle");
  dec_take_a: assert property (DEC_VALID |-> $past(take))
    else $error("decode without a taken word");
  move_quiet_a: assert property (mv_word |=> !DEC_VALID)
    else $error("move first word dispatched");
  move_pair_a: assert property (mv_word ##4 take |=> DEC_VALID && FORMAT == `IFD_FMT_MOVE
      && SRC_ADDR == $past(INSTR_WORD[11:0], 5) && DST_ADDR == $past(INSTR_WORD[11:0]))
    else $error("move addresses wrong");
  table_req_a: assert property (tbl_word |=> TBL_REQ && TBL_WRITE == $past(INSTR_WORD[2]))
    else $error("table request missing");
  flags_load_a: assert property (ALU_FLAGS_WE |=> FLAGS == $past(ALU_FLAGS))
    else $error("flags not loaded");
  bit_field_a: assert property (DEC_VALID && FORMAT == `IFD_FMT_BIT |-> BIT_SEL == $past(INSTR_WORD[11:9]))
    else $error("bit select wrong");
  literal_byte_a: assert property (DEC_VALID && FORMAT == `IFD_FMT_LIT |-> LITERAL == $past(INSTR_WORD[7:0]))
    else $error("literal wrong");
  access_bank_a: assert property (DEC_VALID && FORMAT == `IFD_FMT_BYTE && !$past(INSTR_WORD[8]) |->
      FILE_ADDR == {$past(INSTR_WORD[7]) ? `IFD_ACCESS_HI : `IFD_ACCESS_LO, $past(INSTR_WORD[7:0])})
    else $error("access bank address wrong");
  dest_select_a: assert property (DEC_VALID && FORMAT == `IFD_FMT_BYTE |-> DEST_ACC == !$past(INSTR_WORD[9]))
    else $error("destination select wrong");
endmodule // ifd_decoder_chk
bind ifd_decoder ifd_decoder_chk u_ifd_decoder_chk (.*);

// file: tb/test_instruction_format_decoder.sv
// self-checking bench for the instruction format decoder
`include "ifd_defines.vh"
module test_instruction_format_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK_SYS, RST_B, INSTR_VALID, ALU_FLAGS_WE, TBL_RVALID, WR, RD;
  logic        FETCH, DEC_VALID, IS_NOP, DEST_ACC, FAST_SHADOW, COND_EXTEND, TBL_REQ, TBL_WRITE;
  logic [1:0]  PTR_SEL, EXEC_CYCLES;
  logic [2:0]  BIT_SEL;
  logic [3:0]  FORMAT;
  logic [4:0]  ALU_FLAGS, FLAGS;
  logic [7:0]  OPERAND_DATA, TBL_RDATA, WDATA, RDATA, LITERAL, TBL_WDATA, rdq;
  logic [10:0] BR_OFFSET;
  logic [11:0] ADDR, FILE_ADDR, SRC_ADDR, DST_ADDR, PTR_VALUE;
  logic [15:0] INSTR_WORD, prod;
  logic [19:0] TARGET;
  logic [20:0] TBL_ADDR, ptr, ta;
  logic [31:0] seed, v;
  int          miscompares = 0;
  int          compares = 0;
  localparam logic [11:0] RA [12] = '{12'hFE8, 12'hFF3, 12'hFF4, 12'hFF5, 12'hFF6, 12'hFF7,
                                      12'hFF8, 12'hFF9, 12'hFFA, 12'hFFB, 12'hFE0, 12'hFE1};
  ifd_decoder u_ifd_decoder (.*);
  ifd_prog_mem u_ifd_prog_mem (.*);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] msk(input logic [11:0] a);
    return (a == 12'hFF8 || a == 12'hFE1) ? 8'h1F : (a == 12'hFE0 ? 8'h0F : 8'hFF);
  endfunction
  task automatic summarize();
    if (miscompares == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // read data is picked up at the edge, before that edge's updates land
  task automatic bus(input logic w, input logic r, input logic [11:0] a, input logic [7:0] d);
    WR <= w;
    RD <= r;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK_SYS);
    rdq = RDATA;
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
    bus(1'b0, 1'b0, a, 8'h00);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, a, 8'h00);
    chk(rdq, e);
  endtask
  task automatic feed(input logic [15:0] w);
    u_ifd_prog_mem.rom[u_ifd_prog_mem.fill] = w;
    u_ifd_prog_mem.fill++;
  endtask
  task automatic wait_dec();
    int n;
    n = 0;
    do begin
      @(posedge CLK_SYS);
      #1;
      n++;
    end while (DEC_VALID !== 1'b1 && n < 20);
    if (DEC_VALID !== 1'b1) begin
      miscompares++;
      summarize();
    end
  endtask
  task automatic ptrchk();
    rdchk(12'hFF6, ptr[7:0]);
    rdchk(12'hFF7, ptr[15:8]);
    rdchk(12'hFF8, {3'b000, ptr[20:16]});
  endtask
  initial begin
    CLK_SYS = 1'b0;
    forever #10 CLK_SYS = ~CLK_SYS;
  end
  initial begin
    {RST_B, WR, RD, ALU_FLAGS_WE, ALU_FLAGS, ADDR, WDATA, OPERAND_DATA} = '0;
    seed = 32'h711E8C5D;
    repeat (3) @(posedge CLK_SYS);
    #1;
    chk({FETCH, DEC_VALID, TBL_REQ, FLAGS, RDATA}, 32'h0);
    RST_B <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      v = rnd();
      wr(RA[i], v[7:0]);
      rdchk(RA[i], v[7:0] & msk(RA[i]));
    end
    wr(12'h005, 8'hA5);
    rdchk(12'h005, 8'h00);
    v = rnd();
    ALU_FLAGS <= v[4:0];
    ALU_FLAGS_WE <= 1'b1;
    // software write in the same cycle must lose to the arithmetic unit
    bus(1'b1, 1'b0, 12'hFE1, ~v[7:0]);
    ALU_FLAGS_WE <= 1'b0;
    bus(1'b0, 1'b0, 12'h000, 8'h00);
    chk(FLAGS, v[4:0]);
    rdchk(12'hFE1, {3'b000, v[4:0]});
    for (int i = 0; i < 3; i++) begin
      v = rnd();
      if (i == 0) v[23:12] = 12'hFFF;
      feed({4'hC, v[11:0]});
      feed({4'hF, v[23:12]});
      wait_dec();
      chk(FORMAT, `IFD_FMT_MOVE);
      chk({SRC_ADDR, DST_ADDR}, {v[11:0], v[23:12]});
    end
    feed({4'hF, v[11:0]});
    wait_dec();
    chk({IS_NOP, FORMAT}, {1'b1, `IFD_FMT_NOP});
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      if (i == 0) v = 32'hFFFFFFFF;
      feed({6'b001001, v[9:0]});
      wait_dec();
      chk({FORMAT, DEST_ACC}, {`IFD_FMT_BYTE, !v[9]});
      feed({4'h8, v[11:0]});
      wait_dec();
      chk({FORMAT, BIT_SEL}, {`IFD_FMT_BIT, v[11:9]});
      feed({5'b00001, v[10:0]});
      wait_dec();
      chk({FORMAT, LITERAL}, {`IFD_FMT_LIT, v[7:0]});
      feed({8'hEF, v[7:0]});
      feed({4'hF, v[19:8]});
      wait_dec();
      chk({FORMAT, EXEC_CYCLES, TARGET}, {`IFD_FMT_GOTO, 2'h2, v[19:0]});
      feed({7'h76, v[20], v[7:0]});
      feed({4'hF, v[19:8]});
      wait_dec();
      chk({FORMAT, FAST_SHADOW, TARGET}, {`IFD_FMT_CALL, v[20], v[19:0]});
      feed({15'h0008, v[21]});
      wait_dec();
      chk({FORMAT, FAST_SHADOW, EXEC_CYCLES}, {`IFD_FMT_RET, v[21], 2'h2});
      feed({5'h1A, v[10:0]});
      wait_dec();
      chk({FORMAT, BR_OFFSET}, {`IFD_FMT_BRANCH, v[10:0]});
      feed({5'h1C, v[10:0]});
      wait_dec();
      chk({FORMAT, COND_EXTEND, BR_OFFSET}, {`IFD_FMT_BCOND, 1'b1, {3{v[7]}}, v[7:0]});
      feed({8'hEE, 2'b00, v[5:0]});
      feed({8'hF0, v[15:8]});
      wait_dec();
      chk({FORMAT, PTR_SEL, PTR_VALUE}, {`IFD_FMT_PTR_LOAD, v[5:4], v[3:0], v[15:8]});
    end
    // byte op writing the program counter low byte through the access bank
    feed(16'h26F9);
    wait_dec();
    chk({FORMAT, FILE_ADDR, EXEC_CYCLES}, {`IFD_FMT_BYTE, 12'hFF9, 2'h2});
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      if (i < 2) v[7:0] = 8'h7F + i[7:0];
      prod = v[15:8] * v[23:16];
      wr(12'hFE8, v[15:8]);
      wr(12'hFE0, {4'h0, v[27:24]});
      OPERAND_DATA <= v[23:16];
      feed({7'b0000001, i[1], v[7:0]});
      wait_dec();
      chk(FILE_ADDR, i[1] ? {v[27:24], v[7:0]} : {v[7] ? 4'hF : 4'h0, v[7:0]});
      rdchk(12'hFF4, prod[15:8]);
      rdchk(12'hFF3, prod[7:0]);
    end
    for (int r = 0; r < 2; r++) begin
      v = rnd();
      ptr = r ? v[20:0] : 21'h1FFFFF;
      wr(12'hFF6, ptr[7:0]);
      wr(12'hFF7, ptr[15:8]);
      wr(12'hFF8, {3'b000, ptr[20:16]});
      for (int m = 0; m < 4; m++) begin
        u_ifd_prog_mem.slow = m[0];
        feed({14'h0002, m[1:0]});
        wait_dec();
        ta = m == 3 ? ptr + 21'h000001 : ptr;
        chk({TBL_REQ, TBL_WRITE, TBL_ADDR}, {2'b10, ta});
        if (m == 1 || m == 3) ptr = ptr + 21'h000001;
        if (m == 2) ptr = ptr - 21'h000001;
        ptrchk();
        rdchk(12'hFF5, ta[7:0] ^ 8'h3C);
      end
    end
    feed(16'h000C);
    wait_dec();
    chk({TBL_REQ, TBL_WRITE, TBL_WDATA}, {2'b11, ta[7:0] ^ 8'h3C});
    summarize();
  end
endmodule // test_instruction_format_decoder
